// [src/frame_synced_config_update.sv]
`timescale 1ns/1ps
module frame_synced_config_update
#(
    parameter int LINE_W = 16,
    parameter int ROWS_W = 8,
    parameter int EXPO_W = 16,
    parameter int AFE_W  = 8,
    parameter int ROI_W  = 32,
    parameter int DEC_W  = 4
)
(
    input  wire logic              clk,
    input  wire logic              rstn,
    input  wire logic              ce,
    // Register port from the serial interface decoder
    input  wire logic [8:0]        reg_addr,
    input  wire logic              reg_wr,
    input  wire logic [15:0]       reg_wdata,
    input  wire logic              reg_rd,
    output logic      [15:0]       reg_rdata,
    output logic                   reg_rvalid,
    // Sequencer timing events
    input  wire logic              frame_start,
    input  wire logic              overhead_start,
    // Staged settings held by neighbouring register banks
    input  wire logic [LINE_W-1:0] staged_line_length,
    input  wire logic [ROWS_W-1:0] staged_dark_rows,
    input  wire logic [ROWS_W-1:0] staged_filler_rows,
    input  wire logic [EXPO_W-1:0] staged_exposure,
    input  wire logic [AFE_W-1:0]  staged_afe_gain,
    input  wire logic [ROI_W-1:0]  staged_roi_select,
    input  wire logic [DEC_W-1:0]  decimation_mode,
    // Active settings seen by the sequencer
    output logic      [LINE_W-1:0] line_length,
    output logic      [ROWS_W-1:0] active_dark_rows,
    output logic      [ROWS_W-1:0] active_filler_rows,
    output logic      [EXPO_W-1:0] active_exposure,
    output logic      [AFE_W-1:0]  active_afe_gain,
    output logic      [4:0]        column_amp_setting,
    output logic      [11:0]       digital_amp_value,
    output logic      [ROI_W-1:0]  active_roi_select,
    output logic      [7:0]        active_ref_rows,
    output logic                   blank_frame
);

    // ------------------------------------------------------------
    // Parameter checks
    // ------------------------------------------------------------
    if (LINE_W < 1 || LINE_W > 16 || ROWS_W < 1 || EXPO_W < 1 ||
        AFE_W < 1 || ROI_W < 1 || DEC_W < 1)
    begin : bad_width
        $error("frame_synced_config_update: illegal width");
    end

    // ------------------------------------------------------------
    // Host-visible registers
    // ------------------------------------------------------------
    logic [15:0] gain_cfg;
    logic [15:0] digital_cfg;
    logic [15:0] commit_cfg;
    logic [15:0] ref_cfg;
    logic [15:0] rsvd_cfg;

    // Register writes, masked to the implemented bits
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            gain_cfg    <= frame_sync_pkg::RST_GAIN_CFG;
            digital_cfg <= frame_sync_pkg::RST_DIGITAL;
            commit_cfg  <= frame_sync_pkg::RST_COMMIT;
            ref_cfg     <= frame_sync_pkg::RST_REF_ROWS;
            rsvd_cfg    <= frame_sync_pkg::RST_RSVD_208;
        end
        else if (ce && reg_wr)
        begin
            case (reg_addr)
                frame_sync_pkg::ADDR_GAIN_CFG:
                    gain_cfg <= reg_wdata & frame_sync_pkg::MASK_GAIN_CFG;
                frame_sync_pkg::ADDR_DIGITAL:
                    digital_cfg <= reg_wdata & frame_sync_pkg::MASK_DIGITAL;
                frame_sync_pkg::ADDR_COMMIT:
                    commit_cfg <= reg_wdata & frame_sync_pkg::MASK_COMMIT;
                frame_sync_pkg::ADDR_REF_ROWS:
                    ref_cfg <= reg_wdata & frame_sync_pkg::MASK_REF_ROWS;
                frame_sync_pkg::ADDR_RSVD_208:
                    rsvd_cfg <= reg_wdata & frame_sync_pkg::MASK_RSVD_208;
                default:
                    ;
            endcase
        end
    end

    // Register reads, one cycle later; unmapped reads return zero
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            reg_rdata  <= 16'h0000;
            reg_rvalid <= 1'b0;
        end
        else if (ce)
        begin
            reg_rvalid <= reg_rd;
            case (reg_addr)
                frame_sync_pkg::ADDR_GAIN_CFG: reg_rdata <= gain_cfg;
                frame_sync_pkg::ADDR_DIGITAL:  reg_rdata <= digital_cfg;
                frame_sync_pkg::ADDR_COMMIT:   reg_rdata <= commit_cfg;
                frame_sync_pkg::ADDR_REF_ROWS: reg_rdata <= ref_cfg;
                frame_sync_pkg::ADDR_RSVD_208: reg_rdata <= rsvd_cfg;
                default:                       reg_rdata <= 16'h0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Control fields
    // ------------------------------------------------------------
    logic sync_line;
    logic sync_dark;
    logic sync_fill;
    logic sync_expo;
    logic sync_amp;
    logic sync_roi;
    logic sync_ref;
    logic blank_roi_en;
    logic blank_dec_en;
    logic expo_cont;
    logic gain_lat_comp;
    logic fs;
    logic [4:0]  staged_col_amp;
    logic [11:0] staged_dig_amp;
    logic [7:0]  staged_ref_rows;

    assign sync_line      = commit_cfg[frame_sync_pkg::SYNC_LINE_BIT];
    assign sync_dark      = commit_cfg[frame_sync_pkg::SYNC_DARK_BIT];
    assign sync_fill      = commit_cfg[frame_sync_pkg::SYNC_FILL_BIT];
    assign sync_expo      = commit_cfg[frame_sync_pkg::SYNC_EXPO_BIT];
    assign sync_amp       = commit_cfg[frame_sync_pkg::SYNC_AMP_BIT];
    assign sync_roi       = commit_cfg[frame_sync_pkg::SYNC_ROI_BIT];
    assign sync_ref       = commit_cfg[frame_sync_pkg::SYNC_REF_BIT];
    assign blank_roi_en   = commit_cfg[frame_sync_pkg::BLANK_ROI_BIT];
    assign blank_dec_en   = commit_cfg[frame_sync_pkg::BLANK_DEC_BIT];
    assign expo_cont      = commit_cfg[frame_sync_pkg::EXPO_MODE_BIT];
    assign gain_lat_comp  = gain_cfg[frame_sync_pkg::GAIN_LAT_BIT];
    assign fs             = ce && frame_start;
    assign staged_col_amp = gain_cfg[frame_sync_pkg::COL_AMP_LSB +:
                                     frame_sync_pkg::COL_AMP_W];
    assign staged_dig_amp = digital_cfg[frame_sync_pkg::DIG_AMP_W-1:0];
    assign staged_ref_rows = ref_cfg[frame_sync_pkg::REF_ROWS_W-1:0];

    // ------------------------------------------------------------
    // Frame-synchronised commit of sequencer settings
    // ------------------------------------------------------------
    // Each field copies its staged value at frame start when synced,
    // or every cycle when not
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            line_length        <= '0;
            active_dark_rows   <= '0;
            active_filler_rows <= '0;
            active_ref_rows    <= '0;
        end
        else if (ce)
        begin
            if (!sync_line || frame_start)
                line_length <= staged_line_length;
            if (!sync_dark || frame_start)
                active_dark_rows <= staged_dark_rows;
            if (!sync_fill || frame_start)
                active_filler_rows <= staged_filler_rows;
            if (!sync_ref || frame_start)
                active_ref_rows <= staged_ref_rows;
        end
    end

    // Exposure: the sync bit decides first, then the commit mode
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            active_exposure <= '0;
        else if (ce)
        begin
            if (!sync_expo)
                active_exposure <= staged_exposure;
            else if (expo_cont)
                active_exposure <= staged_exposure;
            else if (overhead_start)
                active_exposure <= staged_exposure;
        end
    end

    // ------------------------------------------------------------
    // Gain path with optional one-frame latency compensation
    // ------------------------------------------------------------
    logic [4:0]       pipe_col_amp;
    logic [11:0]      pipe_dig_amp;
    logic [AFE_W-1:0] pipe_afe;

    // Holding stage filled at every frame start
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            pipe_col_amp <= '0;
            pipe_dig_amp <= '0;
            pipe_afe     <= '0;
        end
        else if (fs)
        begin
            pipe_col_amp <= staged_col_amp;
            pipe_dig_amp <= staged_dig_amp;
            pipe_afe     <= staged_afe_gain;
        end
    end

    // Active gain takes the held copy or the staged copy
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            column_amp_setting <= '0;
            digital_amp_value  <= '0;
            active_afe_gain    <= '0;
        end
        else if (ce)
        begin
            if (!sync_amp)
            begin
                column_amp_setting <= staged_col_amp;
                digital_amp_value  <= staged_dig_amp;
                active_afe_gain    <= staged_afe_gain;
            end
            else if (frame_start && gain_lat_comp)
            begin
                column_amp_setting <= pipe_col_amp;
                digital_amp_value  <= pipe_dig_amp;
                active_afe_gain    <= pipe_afe;
            end
            else if (frame_start)
            begin
                column_amp_setting <= staged_col_amp;
                digital_amp_value  <= staged_dig_amp;
                active_afe_gain    <= staged_afe_gain;
            end
        end
    end

    // ------------------------------------------------------------
    // Region selection and first-frame blanking
    // ------------------------------------------------------------
    logic [ROI_W-1:0] next_roi_select;
    logic [DEC_W-1:0] dec_seen;
    logic             roi_switch;
    logic             dec_switch;
    logic             roi_pend;
    logic             dec_pend;

    // Region selection to be active after this edge
    always_comb
    begin
        if (!sync_roi || frame_start)
            next_roi_select = staged_roi_select;
        else
            next_roi_select = active_roi_select;
    end

    assign roi_switch = blank_roi_en &&
                        (next_roi_select != active_roi_select);
    assign dec_switch = blank_dec_en && (decimation_mode != dec_seen);

    // Active region and last seen decimation mode
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            active_roi_select <= '0;
            dec_seen          <= '0;
        end
        else if (ce)
        begin
            active_roi_select <= next_roi_select;
            dec_seen          <= decimation_mode;
        end
    end

    // Pending switches blank the next frame; a switch at frame start
    // blanks the frame just starting
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            roi_pend    <= 1'b0;
            dec_pend    <= 1'b0;
            blank_frame <= 1'b0;
        end
        else if (fs)
        begin
            blank_frame <= roi_pend || roi_switch ||
                           dec_pend || dec_switch;
            roi_pend    <= 1'b0;
            dec_pend    <= 1'b0;
        end
        else if (ce)
        begin
            roi_pend <= roi_pend || roi_switch;
            dec_pend <= dec_pend || dec_switch;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence fs_s;
        ce && frame_start;
    endsequence

    sequence idle_s;
        ce && !frame_start;
    endsequence

    gain_next_a: assert property (@(posedge clk) disable iff (!rstn)
        (fs_s and sync_amp && !gain_lat_comp) |=>
            column_amp_setting == $past(staged_col_amp))
        else $error("gain not applied at frame start");

    gain_late_a: assert property (@(posedge clk) disable iff (!rstn)
        (fs_s and sync_amp && gain_lat_comp) |=>
            (column_amp_setting == $past(pipe_col_amp)) &&
            (pipe_col_amp == $past(staged_col_amp)))
        else $error("compensated gain not one frame late");

    line_hold_a: assert property (@(posedge clk) disable iff (!rstn)
        (idle_s and sync_line) |=> $stable(line_length))
        else $error("line length changed mid frame");

    line_free_a: assert property (@(posedge clk) disable iff (!rstn)
        (ce && !sync_line) |=>
            line_length == $past(staged_line_length))
        else $error("unsynced line length not followed");

    ref_hold_a: assert property (@(posedge clk) disable iff (!rstn)
        (idle_s and sync_ref) |=> $stable(active_ref_rows))
        else $error("reference rows changed mid frame");

    expo_held_a: assert property (@(posedge clk) disable iff (!rstn)
        (ce && sync_expo && !expo_cont) |=>
            (active_exposure == ($past(overhead_start) ?
             $past(staged_exposure) : $past(active_exposure))))
        else $error("exposure not latched at overhead start");

    expo_cont_a: assert property (@(posedge clk) disable iff (!rstn)
        (ce && sync_expo && expo_cont) |=>
            active_exposure == $past(staged_exposure))
        else $error("continuous exposure not followed");

    roi_blank_a: assert property (@(posedge clk) disable iff (!rstn)
        (fs_s and roi_switch) |=> blank_frame)
        else $error("region switch frame not blanked");

    dec_clear_a: assert property (@(posedge clk) disable iff (!rstn)
        (fs_s and !roi_pend && !roi_switch && !dec_pend && !dec_switch)
            |=> !blank_frame)
        else $error("frame blanked without a switch");

endmodule

// [common/frame_sync_pkg.sv]
package frame_sync_pkg;

    // ------------------------------------------------------------
    // Register addresses
    // ------------------------------------------------------------
    localparam logic [8:0] ADDR_GAIN_CFG = 9'h0_cc;
    localparam logic [8:0] ADDR_DIGITAL  = 9'h0_cd;
    localparam logic [8:0] ADDR_COMMIT   = 9'h0_ce;
    localparam logic [8:0] ADDR_REF_ROWS = 9'h0_cf;
    localparam logic [8:0] ADDR_RSVD_208 = 9'h0_d0;

    // ------------------------------------------------------------
    // Reset values and readable bit masks
    // ------------------------------------------------------------
    localparam logic [15:0] RST_GAIN_CFG  = 16'h01e3;
    localparam logic [15:0] RST_DIGITAL   = 16'h0080;
    localparam logic [15:0] RST_COMMIT    = 16'h037f;
    localparam logic [15:0] RST_REF_ROWS  = 16'h0000;
    localparam logic [15:0] RST_RSVD_208  = 16'h4f00;
    localparam logic [15:0] MASK_GAIN_CFG = 16'h3fff;
    localparam logic [15:0] MASK_DIGITAL  = 16'h0fff;
    localparam logic [15:0] MASK_COMMIT   = 16'h077f;
    localparam logic [15:0] MASK_REF_ROWS = 16'h00ff;
    localparam logic [15:0] MASK_RSVD_208 = 16'hffff;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int COL_AMP_LSB    = 0;
    localparam int COL_AMP_W      = 5;
    localparam int GAIN_LAT_BIT   = 13;
    localparam int DIG_AMP_W      = 12;
    localparam int REF_ROWS_W     = 8;
    localparam int SYNC_LINE_BIT  = 0;
    localparam int SYNC_DARK_BIT  = 1;
    localparam int SYNC_FILL_BIT  = 2;
    localparam int SYNC_EXPO_BIT  = 3;
    localparam int SYNC_AMP_BIT   = 4;
    localparam int SYNC_ROI_BIT   = 5;
    localparam int SYNC_REF_BIT   = 6;
    localparam int BLANK_ROI_BIT  = 8;
    localparam int BLANK_DEC_BIT  = 9;
    localparam int EXPO_MODE_BIT  = 10;

endpackage

// [test/host_port_model.sv]
`timescale 1ns/1ps
// --------------------------------------------------------------
// Host controller driving the register port
// --------------------------------------------------------------
module host_port_model
(
    input  wire logic        clk,
    output logic      [8:0]  reg_addr,
    output logic             reg_wr,
    output logic      [15:0] reg_wdata,
    output logic             reg_rd,
    input  wire logic [15:0] reg_rdata,
    input  wire logic        reg_rvalid
);
    // Idle bus at time zero
    initial
    begin
        reg_addr = 9'h000;
        reg_wr = 1'b0;
        reg_wdata = 16'h0000;
        reg_rd = 1'b0;
    end

    // One-cycle write strobe, bus scrambled once released
    task automatic wr(input logic [8:0] a, input logic [15:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask

    // Read strobe held until the answer is taken, bounded wait
    task automatic rd(input logic [8:0] a, output logic [15:0] d);
        int n;
        logic ok;
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1'b1;
        ok = 1'b0;
        d = 16'hxxxx;
        for (n = 0; n < 4 && !ok; n++)
        begin
            @(negedge clk);
            if (reg_rvalid === 1'b1)
            begin
                ok = 1'b1;
                d = reg_rdata;
            end
        end
        reg_rd = 1'b0;
        reg_addr = ~a;
    endtask
endmodule

// [test/frame_synced_config_update_test.sv]
`timescale 1ns/1ps
module frame_synced_config_update_test;
    // --------------------------------------------------------------
    // Bench signals
    // --------------------------------------------------------------
    logic        clk, rstn, ce, frame_start, overhead_start;
    logic [8:0]  reg_addr;
    logic        reg_wr, reg_rd, reg_rvalid, blank_frame;
    logic [15:0] reg_wdata, reg_rdata, line_length, active_exposure;
    logic [15:0] staged_line_length, staged_exposure;
    logic [7:0]  staged_dark_rows, staged_filler_rows, staged_afe_gain;
    logic [7:0]  active_dark_rows, active_filler_rows, active_afe_gain;
    logic [7:0]  active_ref_rows;
    logic [31:0] staged_roi_select, active_roi_select;
    logic [3:0]  decimation_mode;
    logic [4:0]  column_amp_setting;
    logic [11:0] digital_amp_value;
    int          fails, comparisons;
    logic [8:0]  addr_tab [6];
    logic [15:0] rst_tab [6];
    logic [15:0] msk_tab [6];

    frame_synced_config_update dut
    (
        .clk(clk), .rstn(rstn), .ce(ce), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .frame_start(frame_start), .overhead_start(overhead_start),
        .staged_line_length(staged_line_length),
        .staged_dark_rows(staged_dark_rows),
        .staged_filler_rows(staged_filler_rows),
        .staged_exposure(staged_exposure),
        .staged_afe_gain(staged_afe_gain),
        .staged_roi_select(staged_roi_select),
        .decimation_mode(decimation_mode), .line_length(line_length),
        .active_dark_rows(active_dark_rows),
        .active_filler_rows(active_filler_rows),
        .active_exposure(active_exposure),
        .active_afe_gain(active_afe_gain),
        .column_amp_setting(column_amp_setting),
        .digital_amp_value(digital_amp_value),
        .active_roi_select(active_roi_select),
        .active_ref_rows(active_ref_rows), .blank_frame(blank_frame)
    );

    host_port_model host
    (
        .clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid)
    );

    // --------------------------------------------------------------
    // Clock, helpers and checks
    // --------------------------------------------------------------
    // 40 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            fails++;
            $display("Error at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic chk_reg(input logic [8:0] a, input logic [15:0] exp);
        logic [15:0] d;
        host.rd(a, d);
        chk_val({16'h0000, d}, {16'h0000, exp});
    endtask

    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask

    // One-cycle pulses, then let the edge updates land
    task automatic frame();
        @(negedge clk);
        frame_start = 1'b1;
        @(negedge clk);
        frame_start = 1'b0;
        @(negedge clk);
    endtask

    task automatic overhead();
        @(negedge clk);
        overhead_start = 1'b1;
        @(negedge clk);
        overhead_start = 1'b0;
        @(negedge clk);
    endtask

    task automatic set_staged(input logic [15:0] v);
        staged_line_length = v;
        staged_dark_rows = v[7:0];
        staged_filler_rows = v[15:8];
        staged_exposure = ~v;
        staged_afe_gain = v[11:4];
        staged_roi_select = {v, ~v};
    endtask

    task automatic chk_active(input logic [15:0] v);
        chk_val({16'h0000, line_length}, {16'h0000, v});
        chk_val(32'(active_dark_rows), 32'(v[7:0]));
        chk_val(32'(active_filler_rows), 32'(v[15:8]));
        chk_val({16'h0000, active_exposure}, {16'h0000, ~v});
        chk_val(32'(active_afe_gain), 32'(v[11:4]));
        chk_val(active_roi_select, {v, ~v});
    endtask

    task automatic end_sim();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Watchdog against a hung handshake
    initial
    begin
        repeat (20000) @(posedge clk);
        fails++;
        end_sim();
    end

    // --------------------------------------------------------------
    // Test sequence
    // --------------------------------------------------------------
    initial
    begin
        fails = 0;
        comparisons = 0;
        rstn = 1'b0;
        ce = 1'b1;
        frame_start = 1'b0;
        overhead_start = 1'b0;
        decimation_mode = 4'h0;
        set_staged(16'h0000);
        addr_tab = '{frame_sync_pkg::ADDR_GAIN_CFG,
                     frame_sync_pkg::ADDR_DIGITAL,
                     frame_sync_pkg::ADDR_COMMIT, frame_sync_pkg::ADDR_REF_ROWS,
                     frame_sync_pkg::ADDR_RSVD_208, 9'h0d1};
        rst_tab = '{frame_sync_pkg::RST_GAIN_CFG, frame_sync_pkg::RST_DIGITAL,
                    frame_sync_pkg::RST_COMMIT, frame_sync_pkg::RST_REF_ROWS,
                    frame_sync_pkg::RST_RSVD_208, 16'h0000};
        msk_tab = '{frame_sync_pkg::MASK_GAIN_CFG,
                    frame_sync_pkg::MASK_DIGITAL,
                    frame_sync_pkg::MASK_COMMIT, frame_sync_pkg::MASK_REF_ROWS,
                    frame_sync_pkg::MASK_RSVD_208, 16'h0000};
        repeat (20) @(negedge clk);
        rstn = 1'b1;
        // Reset values, writable masks and the unmapped address
        for (int i = 0; i < 6; i++)
        begin
            chk_reg(addr_tab[i], rst_tab[i]);
            host.wr(addr_tab[i], 16'hffff);
            chk_reg(addr_tab[i], msk_tab[i]);
            host.wr(addr_tab[i], rst_tab[i]);
        end
        $display("test 1 done");
        // Synced settings commit at frame start, exposure at overhead start; unsynced follow
        set_staged(16'h1234);
        frame();
        overhead();
        chk_active(16'h1234);
        set_staged(16'hbeef);
        idle(3);
        chk_active(16'h1234);
        host.wr(frame_sync_pkg::ADDR_COMMIT, 16'h0300);
        idle(2);
        chk_active(16'hbeef);
        host.wr(frame_sync_pkg::ADDR_COMMIT, 16'h037f);
        $display("test 2 done");
        // Gain commit with and without latency compensation
        host.wr(frame_sync_pkg::ADDR_GAIN_CFG, 16'h0005);
        host.wr(frame_sync_pkg::ADDR_DIGITAL, 16'h0123);
        idle(2);
        chk_val({27'h000_0000, column_amp_setting}, 32'h3);
        chk_val({20'h0_0000, digital_amp_value}, 32'h80);
        frame();
        chk_val({27'h000_0000, column_amp_setting}, 32'h5);
        chk_val({20'h0_0000, digital_amp_value}, 32'h123);
        host.wr(frame_sync_pkg::ADDR_GAIN_CFG, 16'h2005);
        frame();
        frame();
        staged_afe_gain = 8'h5a;
        host.wr(frame_sync_pkg::ADDR_GAIN_CFG, 16'h2009);
        frame();
        chk_val({27'h000_0000, column_amp_setting}, 32'h5);
        chk_val({24'h00_0000, active_afe_gain}, 32'hee);
        frame();
        chk_val({27'h000_0000, column_amp_setting}, 32'h9);
        chk_val({24'h00_0000, active_afe_gain}, 32'h5a);
        host.wr(frame_sync_pkg::ADDR_GAIN_CFG, 16'h0003);
        $display("test 3 done");
        // Exposure commit point per mode
        staged_exposure = 16'h1111;
        frame();
        chk_val({16'h0000, active_exposure}, 32'h4110);
        overhead();
        chk_val({16'h0000, active_exposure}, 32'h1111);
        host.wr(frame_sync_pkg::ADDR_COMMIT, 16'h077f);
        staged_exposure = 16'h2222;
        idle(2);
        chk_val({16'h0000, active_exposure}, 32'h2222);
        host.wr(frame_sync_pkg::ADDR_COMMIT, 16'h0777);
        staged_exposure = 16'h3333;
        idle(2);
        chk_val({16'h0000, active_exposure}, 32'h3333);
        host.wr(frame_sync_pkg::ADDR_COMMIT, 16'h037f);
        $display("test 4 done");
        // Reference rows, full range and zero
        host.wr(frame_sync_pkg::ADDR_REF_ROWS, 16'h00ff);
        idle(2);
        chk_val({24'h00_0000, active_ref_rows}, 32'h0);
        frame();
        chk_val({24'h00_0000, active_ref_rows}, 32'hff);
        host.wr(frame_sync_pkg::ADDR_REF_ROWS, 16'h0000);
        frame();
        chk_val({24'h00_0000, active_ref_rows}, 32'h0);
        $display("test 5 done");
        // Blanking after region and decimation switches
        host.wr(frame_sync_pkg::ADDR_COMMIT, 16'h035f);
        staged_roi_select = 32'hcafe_f00d;
        idle(2);
        chk_val(active_roi_select, 32'hcafe_f00d);
        frame();
        chk_val({31'h0000_0000, blank_frame}, 32'h1);
        frame();
        chk_val({31'h0000_0000, blank_frame}, 32'h0);
        decimation_mode = 4'h5;
        idle(1);
        frame();
        chk_val({31'h0000_0000, blank_frame}, 32'h1);
        frame();
        chk_val({31'h0000_0000, blank_frame}, 32'h0);
        host.wr(frame_sync_pkg::ADDR_COMMIT, 16'h015f);
        decimation_mode = 4'h6;
        idle(1);
        frame();
        chk_val({31'h0000_0000, blank_frame}, 32'h0);
        $display("test 6 done");
        // Frame start ignored while the clock enable is low
        host.wr(frame_sync_pkg::ADDR_COMMIT, 16'h037f);
        staged_line_length = 16'h0777;
        @(negedge clk);
        ce = 1'b0;
        frame();
        ce = 1'b1;
        idle(1);
        chk_val({16'h0000, line_length}, 32'hbeef);
        frame();
        chk_val({16'h0000, line_length}, 32'h0777);
        $display("test 7 done");
        end_sim();
    end
endmodule
